/* File: src/pump_ctrl_pkg.sv */
package pump_ctrl_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_PUMP = 8'h09;
    localparam logic [7:0] IDX_BIAS = 8'h0A;
    localparam logic [7:0] IDX_DET = 8'h0B;
    localparam logic [7:0] IDX_LOCK = 8'h0F;
    localparam logic [1:0] WORD_LSBS = 2'h0;

    localparam logic [23:0] PUMP_RST = 24'h000000;
    localparam logic [23:0] PUMP_WMASK = 24'hFFFF9C;
    localparam logic [1:0] BIAS_RST = 2'h0;
    localparam logic [11:0] DET_RST = 12'h870;

    // Pump current register fields
    localparam int SRC_OFS_LSB = 2;
    localparam int SNK_OFS_LSB = 7;
    localparam int SRC_TRIM_LSB = 10;
    localparam int SNK_TRIM_LSB = 14;
    localparam int SRC_MAIN_LSB = 18;
    localparam int SNK_MAIN_LSB = 21;
    localparam logic [2:0] MAIN_OFF = 3'h0;

    // Detector register fields
    localparam int DELAY_LSB = 0;
    localparam int SWAP_BIT = 3;
    localparam int RAISE_EN_BIT = 4;
    localparam int LOWER_EN_BIT = 5;
    localparam int LOCK_OE_BIT = 6;
    localparam int FORCE_RAISE_BIT = 7;
    localparam int FORCE_LOWER_BIT = 8;
    localparam int MUTE_BIT = 9;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    typedef struct packed {
        logic [2:0] source_offset;
        logic [2:0] sink_offset;
        logic [3:0] source_trim;
        logic [3:0] sink_trim;
        logic [2:0] source_main;
        logic [2:0] sink_main;
        logic [1:0] amp_bias;
        logic amp_active;
        logic source_tristate;
        logic sink_tristate;
        logic [2:0] reset_delay;
    } pump_codes_type;

    typedef struct packed {
        logic out;
    } gate_state_type;

    typedef struct packed {
        logic [23:0] pump;
        logic [1:0] bias;
        logic [11:0] det;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic ready;
        pump_codes_type codes;
        logic lock_out;
        logic lock_oe_n;
    } ctrl_state_type;

endpackage

/* File: src/detector_gate_cell.sv */
`timescale 1ns/1ps
module detector_gate_cell
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic raw,
    input wire logic enable,
    input wire logic force_on,
    input wire logic mute,
    input wire logic locked,
    output logic out_q
);
    pump_ctrl_pkg::gate_state_type s_q;
    pump_ctrl_pkg::gate_state_type s_d;
    logic pass;

    always_comb
    begin
        s_d = s_q;
        // Mute mode opens both paths while unlocked
        if (mute)
            pass = !locked || enable; // [R14]
        else
            pass = enable; // [R15]
        // Forcing beats both the enable and the mute gating
        s_d.out = force_on || (raw && pass); // [R17]
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign out_q = s_q.out;
endmodule // detector_gate_cell

/* File: src/phase_detector_pump_control.sv */
// Notes on behaviour
// [R1] Source offset code, three bits, 55 uA steps, reset zero.
// [R2] Sink offset code, three bits, 55 uA steps, reset zero.
// [R3] Source trim code, four binary-weighted bits of 7 uA, zero means none.
// [R4] Sink trim code, four bits of 7 uA each, reset zero.
// [R5] Main codes step 500 uA; zero tristates pump when detector disabled.
// [R6] Software writes zero to pump register bits 1:0 and 6:5.
// [R7] Amplifier bias code of two bits, active only with pump enabled.
// [R8] Software programs detector reset delay to 010, never 000 in integer mode.
// [R9] Swap bit exchanges the two detector inputs.
// [R10] Raise and lower enables, reset one, gate outputs under mute setting.
// [R11] Lock output enable drives the lock flag onto the lock pin.
// [R12] Force-raise holds the raise output active, reset zero.
// [R13] Force-lower holds the lower output active, reset zero.
// [R14] Mute set: locked disables disabled outputs; unlocked passes both.
// [R15] Mute clear: enables gate outputs at all times.
// [R16] Lock flag drives muting and reads at its own status register.
// [R17] A force bit overrides enable and mute gating.
// [R18] Spare detector bits 10 and 11 are plain storage, reset 0 and 1.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module phase_detector_pump_control
#(
    parameter int ADDR_W = 32
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic pump_enable_bit,
    input wire logic detector_enable,
    input wire logic locked,
    input wire logic ref_raise_raw,
    input wire logic ref_lower_raw,
    output pump_ctrl_pkg::pump_codes_type pump_codes,
    output logic detector_raise,
    output logic detector_lower,
    output logic lock_serial_out_pin_o,
    output logic lock_serial_out_pin_oe_n
);
    pump_ctrl_pkg::ctrl_state_type s_q;
    pump_ctrl_pkg::ctrl_state_type s_d;
    logic [7:0] req_idx;
    logic req_taken;
    logic raise_in;
    logic lower_in;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave and register file

    assign req_idx = haddr[9:2];
    assign req_taken = hsel && hready
        && (htrans == pump_ctrl_pkg::HTRANS_NONSEQ);

    always_comb
    begin
        s_d = s_q;
        s_d.ready = 1'b1;
        // Write data arrives one cycle after its address phase
        if (s_q.wr_pend)
        begin
            case (s_q.wr_idx)
                pump_ctrl_pkg::IDX_PUMP:
                    s_d.pump = hwdata[23:0] & pump_ctrl_pkg::PUMP_WMASK; // [R6]
                pump_ctrl_pkg::IDX_BIAS:
                    s_d.bias = hwdata[1:0]; // [R7]
                pump_ctrl_pkg::IDX_DET:
                    s_d.det = hwdata[11:0]; // [R18]
                default:
                    s_d.det = s_d.det;
            endcase
        end
        s_d.wr_pend = req_taken && hwrite;
        s_d.wr_idx = req_idx;
        // Reads see the post-write value so write then read needs no stall
        if (req_taken && !hwrite)
        begin
            case (req_idx)
                pump_ctrl_pkg::IDX_PUMP:
                    s_d.rdata = {8'h00, s_d.pump};
                pump_ctrl_pkg::IDX_BIAS:
                    s_d.rdata = {30'h00000000, s_d.bias};
                pump_ctrl_pkg::IDX_DET:
                    s_d.rdata = {20'h00000, s_d.det};
                pump_ctrl_pkg::IDX_LOCK:
                    s_d.rdata = {31'h00000000, locked}; // [R16]
                default:
                    s_d.rdata = 32'h00000000;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Analog code outputs, registered from the stored fields and the enable inputs
        s_d.codes.source_offset =
            s_q.pump[pump_ctrl_pkg::SRC_OFS_LSB +: 3]; // [R1]
        s_d.codes.sink_offset =
            s_q.pump[pump_ctrl_pkg::SNK_OFS_LSB +: 3]; // [R2]
        s_d.codes.source_trim =
            s_q.pump[pump_ctrl_pkg::SRC_TRIM_LSB +: 4]; // [R3]
        s_d.codes.sink_trim =
            s_q.pump[pump_ctrl_pkg::SNK_TRIM_LSB +: 4]; // [R4]
        s_d.codes.source_main =
            s_q.pump[pump_ctrl_pkg::SRC_MAIN_LSB +: 3]; // [R5]
        s_d.codes.sink_main =
            s_q.pump[pump_ctrl_pkg::SNK_MAIN_LSB +: 3]; // [R5]
        s_d.codes.source_tristate = !detector_enable
            && (s_d.codes.source_main == pump_ctrl_pkg::MAIN_OFF); // [R5]
        s_d.codes.sink_tristate = !detector_enable
            && (s_d.codes.sink_main == pump_ctrl_pkg::MAIN_OFF); // [R5]
        s_d.codes.amp_bias = s_q.bias; // [R7]
        s_d.codes.amp_active = pump_enable_bit; // [R7]
        // Delay is passed on as written; no guard against 000 here
        s_d.codes.reset_delay = s_q.det[pump_ctrl_pkg::DELAY_LSB +: 3];

        s_d.lock_out = locked; // [R11]
        s_d.lock_oe_n = !s_q.det[pump_ctrl_pkg::LOCK_OE_BIT]; // [R11]
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.pump <= pump_ctrl_pkg::PUMP_RST;
            s_q.bias <= pump_ctrl_pkg::BIAS_RST;
            s_q.det <= pump_ctrl_pkg::DET_RST; // [R10]
            s_q.lock_oe_n <= 1'b1;
        end
        else if (ce)
            s_q <= s_d;
    end

    assign hreadyout = s_q.ready;
    assign hrdata = s_q.rdata;
    assign hresp = pump_ctrl_pkg::HRESP_OKAY;
    assign pump_codes = s_q.codes;
    assign lock_serial_out_pin_o = s_q.lock_out;
    assign lock_serial_out_pin_oe_n = s_q.lock_oe_n;

    ////////////////////////////////////////////////////////////////////////
    // Detector output gating

    // Swap exchanges the two comparison inputs, which flips the polarity
    assign raise_in = s_q.det[pump_ctrl_pkg::SWAP_BIT] ?
        ref_lower_raw : ref_raise_raw; // [R9]
    assign lower_in = s_q.det[pump_ctrl_pkg::SWAP_BIT] ?
        ref_raise_raw : ref_lower_raw; // [R9]

    detector_gate_cell raise_cell
    (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .raw(raise_in),
        .enable(s_q.det[pump_ctrl_pkg::RAISE_EN_BIT]), // [R10]
        .force_on(s_q.det[pump_ctrl_pkg::FORCE_RAISE_BIT]), // [R12]
        .mute(s_q.det[pump_ctrl_pkg::MUTE_BIT]),
        .locked(locked), // [R16]
        .out_q(detector_raise)
    );

    detector_gate_cell lower_cell
    (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .raw(lower_in),
        .enable(s_q.det[pump_ctrl_pkg::LOWER_EN_BIT]), // [R10]
        .force_on(s_q.det[pump_ctrl_pkg::FORCE_LOWER_BIT]), // [R13]
        .mute(s_q.det[pump_ctrl_pkg::MUTE_BIT]),
        .locked(locked), // [R16]
        .out_q(detector_lower)
    );
endmodule // phase_detector_pump_control

/* File: dv/pump_monitor.sv */
`timescale 1ns/1ps
module pump_monitor
#(
    parameter int ADDR_W = 32
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic pump_enable_bit,
    input wire logic detector_enable,
    input wire logic locked,
    input wire pump_ctrl_pkg::pump_codes_type pump_codes,
    input wire logic lock_serial_out_pin_o
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////
    a_resp_okay: assert property (hresp == 1'h0) else $error("bad resp");
    // The edge that releases reset still samples rst high, so it opens nothing
    a_ready_up: assert property (ce && !rst |=> hreadyout)
        else $error("no ready");
    a_lock_pin: assert property (ce && !rst |=>
        lock_serial_out_pin_o == $past(locked)) else $error("lock pin lags");
    a_src_tristate: assert property (ce && !rst |=>
        pump_codes.source_tristate ==
        (pump_codes.source_main == 3'h0 && !$past(detector_enable)))
        else $error("source tristate wrong");
    a_snk_tristate: assert property (ce && !rst |=>
        pump_codes.sink_tristate ==
        (pump_codes.sink_main == 3'h0 && !$past(detector_enable)))
        else $error("sink tristate wrong");
    a_amp_follow: assert property (ce && !rst |=>
        pump_codes.amp_active == $past(pump_enable_bit))
        else $error("amp active wrong");
    a_lock_read: assert property (ce && hsel && hready && htrans == 2'h2
        && !hwrite && haddr[9:2] == 8'h0F |=> hrdata == {31'h0, $past(locked)})
        else $error("lock status read wrong");
    a_codes_hold: assert property (!ce |=> $stable(pump_codes))
        else $error("codes moved while frozen");
endmodule // pump_monitor
bind phase_detector_pump_control pump_monitor #(.ADDR_W(ADDR_W)) pump_monitor_i
(
    .mclk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
    .hrdata, .hresp, .pump_enable_bit, .detector_enable, .locked, .pump_codes,
    .lock_serial_out_pin_o
);

/* File: dv/phase_detector_pump_control_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
module phase_detector_pump_control_tb;
    logic mclk = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic pe = 1, de = 1, locked = 0, rr = 0, rl = 0;
    logic hreadyout, hresp, raise, lower, lpo, lpoe_n;
    logic [31:0] hrdata;
    pump_ctrl_pkg::pump_codes_type codes;
    int errors = 0, samples_checked = 0;
    // Detector word, then locked, raw raise, raw lower, expected outputs
    logic [16:0] rows [9] = '{{12'h072, 5'b01010}, {12'h07A, 5'b01001},
        {12'h042, 5'b01100}, {12'h242, 5'b01111}, {12'h242, 5'b11100},
        {12'h262, 5'b11101}, {12'h2C2, 5'b10010}, {12'h342, 5'b10001},
        {12'h072, 5'b11111}};
    always #2.5 mclk = ~mclk;
    phase_detector_pump_control phase_detector_pump_control_i
    (
        .mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .pump_enable_bit(pe), .detector_enable(de),
        .locked(locked), .ref_raise_raw(rr), .ref_lower_raw(rl),
        .pump_codes(codes), .detector_raise(raise), .detector_lower(lower),
        .lock_serial_out_pin_o(lpo), .lock_serial_out_pin_oe_n(lpoe_n)
    );
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Bounded wait so a stuck slave ends the run instead of hanging it
    task wait_rdy;
        int n;
        n = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 20)
        begin
            errors++;
            complete_run;
        end
    endtask
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        wait_rdy;
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    task do_reset;
        rst <= 1;
        repeat (4) @(posedge mclk);
        rst <= 0;
        xfer(0, 32'h24, 0);
        `CHK(rd, 32'h0)
        xfer(0, 32'h28, 0);
        `CHK(rd, 32'h0)
        xfer(0, 32'h2C, 0);
        `CHK(rd, 32'h870)
        `CHK(lpoe_n, 1'b0)
        $display("reset test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset;
        foreach (rows[i])
        begin
            // Every row keeps the reset delay at 010
            xfer(1, 32'h2C, {20'h0, rows[i][16:5]});
            locked <= rows[i][4];
            rr <= rows[i][3];
            rl <= rows[i][2];
            repeat (3) @(posedge mclk);
            `CHK({raise, lower}, rows[i][1:0])
        end
        $display("gating test done");
        de <= 0;
        // Reserved pump bits are written as zero, all others as one
        xfer(1, 32'h24, 32'h00FFFF9C);
        xfer(0, 32'h24, 0);
        `CHK(rd, 32'h00FFFF9C)
        xfer(1, 32'h24, 32'h0081A594);
        xfer(1, 32'h28, 32'h3);
        repeat (2) @(posedge mclk);
        `CHK({codes.source_offset, codes.sink_offset}, 6'o53)
        `CHK({codes.source_trim, codes.sink_trim}, 8'h96)
        `CHK({codes.source_main, codes.sink_main}, 6'o04)
        `CHK({codes.source_tristate, codes.sink_tristate}, 2'h2)
        `CHK({codes.amp_bias, codes.amp_active}, 3'h7)
        `CHK(codes.reset_delay, 3'h2)
        xfer(0, 32'h3C, 0);
        `CHK(rd, 32'h1)
        `CHK(lpo, 1'b1)
        xfer(1, 32'h2C, 32'h002);
        repeat (2) @(posedge mclk);
        `CHK(lpoe_n, 1'b1)
        xfer(1, 32'h30, 32'hFFFF);
        xfer(0, 32'h30, 0);
        `CHK(rd, 32'h0)
        ce <= 0;
        locked <= 0;
        repeat (3) @(posedge mclk);
        `CHK(lpo, 1'b1)
        ce <= 1;
        repeat (3) @(posedge mclk);
        `CHK(lpo, 1'b0)
        $display("register test done");
        do_reset;
        complete_run;
    end
endmodule // phase_detector_pump_control_tb
